// file: logic/tscr_top.sv
`timescale 1ns/1ps
`include "tscr_regs.svh"
// Overview of operation
// RL1: Four-bit channel select picks one of sixteen.
// RL2: Reserved result bits read zero, ignore writes.
// RL3: DMA select routes event to DMA request.
// RL4: Write-only start bit starts software-mode scan.
// RL5: Read-only sixteen-bit accumulated reference count.
// RL6: Threshold upper half holds writable high limit.
// RL7: Threshold lower half holds writable low limit.
// RL8: Electrode oscillator divided by selectable prescaler.
// RL9: Scan number sets modulus counter maximum.
// RL10: Sample period spans counter zero to maximum.
// RL11: Reference cycles counted during sample period.
// RL12: Electrode charge field selects electrode current.
// RL13: Reference charge field selects reference current.
// RL14: Hardware mode waits for hardware trigger.
// RL15: End-of-scan flag set; write one clears.
// RL16: Scan number gives 1..32 accumulated scans.
// RL17: DMA done clears end-of-scan flag.
// RL18: Result counter cleared at each scan start.
module tscr_top import tscr_pkg::*; #(
   parameter int CNT_W = 16,
   parameter int PS_W  = 3
) (
   // Clock, reset and enable.
   input  wire logic        clock,
   input  wire logic        reset,
   input  wire logic        clock_enable,
   // Avalon-MM slave.
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic [31:0]      readdata,
   output logic             waitrequest,
   // Oscillator and trigger inputs from the analog front end.
   input  wire logic        electrode_osc,
   input  wire logic        reference_osc,
   input  wire logic        hardware_trigger,
   // DMA handshake.
   input  wire logic        dma_done,
   output logic             dma_request,
   // Analog settings and busy level.
   output tscr_analog_type  analog_ff,
   output logic             scan_active,
   // Interrupt.
   output logic             irq
);
   tscr_bus_req_type req;             // Bundled bus request.
   tscr_state_type   state_ff;        // Scan controller state.
   logic [3:0]  channel_select;       // Channel to scan.
   logic        dma_request_select;   // Route events to DMA.
   logic        trigger_mode_select;  // 1 selects hardware trigger.
   logic        sense_irq_enable;     // Event enable.
   logic        event_source_select;  // 1 selects end of scan.
   logic [PS_W-1:0] prescale_select;  // Divider exponent.
   logic [4:0]  scan_number;          // Scans minus one.
   logic [2:0]  electrode_charge_current;
   logic [2:0]  reference_charge_current;
   logic [15:0] high_threshold;       // Wakeup high limit.
   logic [15:0] low_threshold;        // Wakeup low limit.
   logic [CNT_W-1:0] result_count_ff; // Accumulated reference count.
   logic [4:0]  modulus_ff;           // Modulus counter.
   logic        end_of_scan_flag;     // Sticky end of scan.
   logic [1:0]  irq_stat_ff;          // Sticky interrupt status.
   logic [1:0]  irq_mask_ff;          // Interrupt mask.
   logic        ack_ff;               // Bus answer phase.
   logic        elec_sync;            // Synchronised electrode level.
   logic        ref_sync;             // Synchronised reference level.
   logic        trig_sync;            // Synchronised trigger level.
   logic        elec_prev_ff;         // Edge detect history.
   logic        ref_prev_ff;
   logic        trig_prev_ff;
   logic        elec_edge;
   logic        ref_edge;
   logic        trig_edge;
   logic        div_tick;             // Divided electrode tick.
   logic        sw_start;             // Software start pulse.
   logic        scan_start;           // Combined start.
   logic        scan_end;             // Last modulus step reached.
   logic        out_of_range;         // Result outside thresholds.
   logic        bus_wr;
   logic        bus_rd;
   logic        fire_event;           // Selected event occurred.

   assign req = '{address: address, read: read, write: write, writedata: writedata};

   // One wait cycle, then the access completes.
   assign bus_wr = req.write && ack_ff;
   assign bus_rd = req.read && ack_ff;

   // Synchronise the asynchronous analog inputs.
   tscr_sync3 u_sync_elec (
      .clock        (clock),
      .reset        (reset),
      .clock_enable (clock_enable),
      .async_in     (electrode_osc),
      .sync_out     (elec_sync)
   );
   tscr_sync3 u_sync_ref (
      .clock        (clock),
      .reset        (reset),
      .clock_enable (clock_enable),
      .async_in     (reference_osc),
      .sync_out     (ref_sync)
   );
   tscr_sync3 u_sync_trig (
      .clock        (clock),
      .reset        (reset),
      .clock_enable (clock_enable),
      .async_in     (hardware_trigger),
      .sync_out     (trig_sync)
   );

   // Remember last synchronised levels for rising-edge detection.
   always_ff @(posedge clock) begin
      if (reset) begin
         elec_prev_ff <= 1'b0;
         ref_prev_ff  <= 1'b0;
         trig_prev_ff <= 1'b0;
      end else if (clock_enable) begin
         elec_prev_ff <= elec_sync;
         ref_prev_ff  <= ref_sync;
         trig_prev_ff <= trig_sync;
      end
   end

   assign elec_edge = elec_sync && !elec_prev_ff;
   assign ref_edge  = ref_sync && !ref_prev_ff;
   assign trig_edge = trig_sync && !trig_prev_ff;

   // Electrode edges feed the prescaler before the modulus counter.
   tscr_prescaler #(.SEL_W(PS_W)) u_prescaler (
      .clock        (clock),
      .reset        (reset),
      .clock_enable (clock_enable),
      .clear        (state_ff == TSCR_CLEAR),
      .sel          (prescale_select),  // see RL8
      .edge_in      (elec_edge),
      .tick         (div_tick)
   );

   // Only a written one in software mode starts; zero does nothing.
   assign sw_start = bus_wr && req.address == `TSCR_OFS_RESULT
                     && req.writedata[`TSCR_RES_START_BIT]
                     && !trigger_mode_select;  // see RL4
   // Hardware mode waits for the trigger edge.
   assign scan_start = (state_ff == TSCR_IDLE)
                       && (sw_start || (trigger_mode_select && trig_edge));  // see RL14
   assign scan_end = div_tick && (modulus_ff == scan_number);  // see RL9 see RL16

   // Scan controller sequencing.
   always_ff @(posedge clock) begin
      if (reset) begin
         state_ff <= TSCR_IDLE;
      end else if (clock_enable) begin
         case (state_ff)
            TSCR_IDLE: begin
               if (scan_start) begin
                  state_ff <= TSCR_CLEAR;
               end
            end
            TSCR_CLEAR: state_ff <= TSCR_SCAN;
            TSCR_SCAN: begin
               if (scan_end) begin
                  state_ff <= TSCR_DONE;
               end
            end
            TSCR_DONE: state_ff <= TSCR_IDLE;
            default: state_ff <= TSCR_IDLE;
         endcase
      end
   end

   // Modulus counter advances one per divided tick from zero.
   always_ff @(posedge clock) begin
      if (reset) begin
         modulus_ff <= 5'h0;
      end else if (clock_enable) begin
         if (state_ff == TSCR_CLEAR) begin
            modulus_ff <= 5'h0;  // see RL10
         end else if (state_ff == TSCR_SCAN && div_tick) begin
            modulus_ff <= modulus_ff + 5'h1;
         end
      end
   end

   // Reference edges during the sample period accumulate the result.
   // The count saturates rather than wrap, so a huge load is not misread.
   always_ff @(posedge clock) begin
      if (reset) begin
         result_count_ff <= '0;
      end else if (clock_enable) begin
         if (state_ff == TSCR_CLEAR) begin
            result_count_ff <= '0;  // see RL18
         end else if (state_ff == TSCR_SCAN && ref_edge && !(&result_count_ff)) begin
            result_count_ff <= result_count_ff + 1'b1;  // see RL11 see RL5
         end
      end
   end

   // A saturated count is an extreme case and never flags out of range.
   assign out_of_range = !(&result_count_ff)
                         && (result_count_ff > high_threshold
                             || result_count_ff < low_threshold);
   assign fire_event = sense_irq_enable
                       && (event_source_select ? end_of_scan_flag
                                               : irq_stat_ff[`TSCR_IRQ_OOR_BIT]);

   // End-of-scan flag: set wins over write-one clear and DMA done.
   always_ff @(posedge clock) begin
      if (reset) begin
         end_of_scan_flag <= 1'b0;
      end else if (clock_enable) begin
         if (state_ff == TSCR_DONE) begin
            end_of_scan_flag <= 1'b1;  // see RL15
         end else if (bus_wr && req.address == `TSCR_OFS_CONTROL
                      && req.writedata[`TSCR_CTL_END_OF_SCAN_FLAG_BIT]) begin
            end_of_scan_flag <= 1'b0;  // see RL15
         end else if (dma_done && dma_request_select) begin
            end_of_scan_flag <= 1'b0;  // see RL17
         end
      end
   end

   // DMA request follows the selected event when DMA is chosen.
   always_ff @(posedge clock) begin
      if (reset) begin
         dma_request <= 1'b0;
      end else if (clock_enable) begin
         dma_request <= dma_request_select && fire_event && !dma_done;  // see RL3
      end
   end

   // Sticky status; set beats the clear-on-read.
   always_ff @(posedge clock) begin
      if (reset) begin
         irq_stat_ff <= 2'h0;
      end else if (clock_enable) begin
         for (int i = 0; i < 2; i++) begin
            if (state_ff == TSCR_DONE && (i == `TSCR_IRQ_EOS_BIT || out_of_range)) begin
               irq_stat_ff[i] <= 1'b1;
            end else if (bus_rd && req.address == `TSCR_OFS_IRQ_STAT) begin
               irq_stat_ff[i] <= 1'b0;
            end
         end
      end
   end

   // Interrupt is suppressed when DMA is selected.
   always_ff @(posedge clock) begin
      if (reset) begin
         irq <= 1'b0;
      end else if (clock_enable) begin
         irq <= |(irq_stat_ff & irq_mask_ff) && !dma_request_select;  // see RL3
      end
   end

   // Software-writable configuration.
   always_ff @(posedge clock) begin
      if (reset) begin
         channel_select           <= 4'h0;
         dma_request_select       <= 1'b0;
         trigger_mode_select      <= 1'b0;
         sense_irq_enable         <= 1'b0;
         event_source_select      <= 1'b0;
         prescale_select          <= '0;
         scan_number              <= 5'h0;
         electrode_charge_current <= 3'h0;
         reference_charge_current <= 3'h0;
         high_threshold           <= 16'h0;
         low_threshold            <= 16'h0;
         irq_mask_ff              <= 2'h0;
      end else if (clock_enable && bus_wr) begin
         case (req.address)
            `TSCR_OFS_CONTROL: begin
               trigger_mode_select      <= req.writedata[`TSCR_CTL_MODE_BIT];
               sense_irq_enable         <= req.writedata[`TSCR_CTL_IE_BIT];
               event_source_select      <= req.writedata[`TSCR_CTL_EVENT_SOURCE_SELECT_BIT];
               prescale_select          <= req.writedata[`TSCR_CTL_PS_HI:`TSCR_CTL_PS_LO];
               scan_number              <= req.writedata[`TSCR_CTL_SCAN_NUMBER_HI:`TSCR_CTL_SCAN_NUMBER_LO];
               electrode_charge_current <= req.writedata[`TSCR_CTL_ECHG_HI:`TSCR_CTL_ECHG_LO];
               reference_charge_current <= req.writedata[`TSCR_CTL_RCHG_HI:`TSCR_CTL_RCHG_LO];
            end
            `TSCR_OFS_RESULT: begin
               channel_select     <= req.writedata[`TSCR_RES_CHAN_HI:`TSCR_RES_CHAN_LO];
               dma_request_select <= req.writedata[`TSCR_RES_DMA_BIT];  // see RL2
            end
            `TSCR_OFS_THRESHOLD: begin
               high_threshold <= req.writedata[31:16];  // see RL6
               low_threshold  <= req.writedata[15:0];   // see RL7
            end
            `TSCR_OFS_IRQ_MASK: irq_mask_ff <= req.writedata[1:0];
            default: ;
         endcase
      end
   end

   // Analog settings and busy level go out registered.
   always_ff @(posedge clock) begin
      if (reset) begin
         analog_ff   <= '0;
         scan_active <= 1'b0;
      end else if (clock_enable) begin
         analog_ff.channel                  <= channel_select;  // see RL1
         analog_ff.electrode_charge_current <= electrode_charge_current;  // see RL12
         analog_ff.reference_charge_current <= reference_charge_current;  // see RL13
         scan_active <= (state_ff == TSCR_CLEAR) || (state_ff == TSCR_SCAN);
      end
   end

   // Bus answer: one wait cycle, then read data with waitrequest low.
   always_ff @(posedge clock) begin
      if (reset) begin
         ack_ff      <= 1'b0;
         waitrequest <= 1'b1;
         readdata    <= `TSCR_RST_WORD;
      end else if (clock_enable) begin
         ack_ff      <= (req.read || req.write) && !ack_ff;
         waitrequest <= !((req.read || req.write) && !ack_ff);
         readdata    <= `TSCR_RST_WORD;
         if (req.read && !ack_ff) begin
            case (req.address)
               `TSCR_OFS_CONTROL: begin
                  readdata[`TSCR_CTL_MODE_BIT] <= trigger_mode_select;
                  readdata[`TSCR_CTL_IE_BIT]   <= sense_irq_enable;
                  readdata[`TSCR_CTL_EVENT_SOURCE_SELECT_BIT] <= event_source_select;
                  readdata[`TSCR_CTL_END_OF_SCAN_FLAG_BIT] <= end_of_scan_flag;
                  readdata[`TSCR_CTL_BUSY_BIT] <= (state_ff != TSCR_IDLE);
                  readdata[`TSCR_CTL_PS_HI:`TSCR_CTL_PS_LO]     <= prescale_select;
                  readdata[`TSCR_CTL_SCAN_NUMBER_HI:`TSCR_CTL_SCAN_NUMBER_LO] <= scan_number;
                  readdata[`TSCR_CTL_ECHG_HI:`TSCR_CTL_ECHG_LO] <= electrode_charge_current;
                  readdata[`TSCR_CTL_RCHG_HI:`TSCR_CTL_RCHG_LO] <= reference_charge_current;
               end
               // Start bit reads zero; reserved ranges stay zero.
               `TSCR_OFS_RESULT: begin
                  readdata[`TSCR_RES_CHAN_HI:`TSCR_RES_CHAN_LO] <= channel_select;
                  readdata[`TSCR_RES_DMA_BIT]                   <= dma_request_select;
                  readdata[`TSCR_RES_CNT_HI:0]                  <= result_count_ff;  // see RL2
               end
               `TSCR_OFS_THRESHOLD: readdata <= {high_threshold, low_threshold};
               `TSCR_OFS_IRQ_STAT:  readdata[1:0] <= irq_stat_ff;
               `TSCR_OFS_IRQ_MASK:  readdata[1:0] <= irq_mask_ff;
               default: ;  // Unmapped reads return zero.
            endcase
         end
      end
   end
endmodule // tscr_top

// file: logic/tscr_regs.svh
`ifndef TSCR_REGS_SVH
`define TSCR_REGS_SVH
// Register byte offsets.
`define TSCR_OFS_CONTROL   5'h00
`define TSCR_OFS_RESULT    5'h04
`define TSCR_OFS_THRESHOLD 5'h08
`define TSCR_OFS_IRQ_STAT  5'h0c
`define TSCR_OFS_IRQ_MASK  5'h10
// Result register field positions.
`define TSCR_RES_CHAN_HI   31
`define TSCR_RES_CHAN_LO   28
`define TSCR_RES_DMA_BIT   23
`define TSCR_RES_START_BIT 22
`define TSCR_RES_CNT_HI    15
// Control register field positions.
`define TSCR_CTL_MODE_BIT  0
`define TSCR_CTL_IE_BIT    1
`define TSCR_CTL_EVENT_SOURCE_SELECT_BIT  2
`define TSCR_CTL_END_OF_SCAN_FLAG_BIT  3
`define TSCR_CTL_BUSY_BIT  4
`define TSCR_CTL_PS_LO     8
`define TSCR_CTL_PS_HI     10
`define TSCR_CTL_SCAN_NUMBER_LO   16
`define TSCR_CTL_SCAN_NUMBER_HI   20
`define TSCR_CTL_ECHG_LO   24
`define TSCR_CTL_ECHG_HI   26
`define TSCR_CTL_RCHG_LO   28
`define TSCR_CTL_RCHG_HI   30
// Interrupt status bits.
`define TSCR_IRQ_EOS_BIT   0
`define TSCR_IRQ_OOR_BIT   1
// Reset values.
`define TSCR_RST_WORD      32'h0000_0000
`endif

// file: logic/tscr_pkg.sv
package tscr_pkg;
   // Scan controller state, one-hot.
   typedef enum logic [3:0] {
      TSCR_IDLE  = 4'h1,
      TSCR_CLEAR = 4'h2,
      TSCR_SCAN  = 4'h4,
      TSCR_DONE  = 4'h8
   } tscr_state_type;

   // Avalon request bundle.
   typedef struct packed {
      logic [4:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
   } tscr_bus_req_type;

   // Analog setting bundle to the oscillators.
   typedef struct packed {
      logic [3:0] channel;
      logic [2:0] electrode_charge_current;
      logic [2:0] reference_charge_current;
   } tscr_analog_type;
endpackage

// file: logic/tscr_sync3.sv
`timescale 1ns/1ps
// Three-stage synchroniser; a change counts once stages two and three agree.
module tscr_sync3 import tscr_pkg::*; (
   // Clock and control.
   input  wire logic clock,
   input  wire logic reset,
   input  wire logic clock_enable,
   // Data.
   input  wire logic async_in,
   output logic      sync_out
);
   logic [2:0] stage_ff;  // Stage 0 feeds only stage 1.

   // Shift the raw level in and update the output only on agreement.
   always_ff @(posedge clock) begin
      if (reset) begin
         stage_ff <= 3'h0;
         sync_out <= 1'b0;
      end else if (clock_enable) begin
         stage_ff <= {stage_ff[1:0], async_in};
         if (stage_ff[1] == stage_ff[2]) begin
            sync_out <= stage_ff[2];
         end
      end
   end
endmodule // tscr_sync3

// file: logic/tscr_prescaler.sv
`timescale 1ns/1ps
// Divides electrode oscillator edges by 2**sel and emits one pulse per period.
module tscr_prescaler import tscr_pkg::*; #(
   parameter int SEL_W = 3
) (
   // Clock and control.
   input  wire logic             clock,
   input  wire logic             reset,
   input  wire logic             clock_enable,
   input  wire logic             clear,
   // Divider setting and input edge.
   input  wire logic [SEL_W-1:0] sel,
   input  wire logic             edge_in,
   output logic                  tick
);
   logic [(1<<SEL_W)-1:0] count_ff;  // Edge counter, wide enough for 128.
   logic [(1<<SEL_W)-1:0] limit;     // Terminal count for the chosen ratio.

   assign limit = (1 << SEL_W)'((1 << sel) - 1);

   // Count input edges; a tick marks reaching the ratio.
   always_ff @(posedge clock) begin
      if (reset || clear) begin
         count_ff <= '0;
         tick     <= 1'b0;
      end else if (clock_enable) begin
         tick <= 1'b0;
         if (edge_in) begin
            if (count_ff == limit) begin
               count_ff <= '0;
               tick     <= 1'b1;
            end else begin
               count_ff <= count_ff + 1'b1;
            end
         end
      end
   end
endmodule // tscr_prescaler

// file: tb/tscr_osc_model.sv
`timescale 1ns/1ps
// Electrode and reference oscillators.
module tscr_osc_model (
   // Clock and control.
   input  wire logic       clock,
   input  wire logic       reset,
   input  wire logic       run,
   // Half periods in cycles, at least two.
   input  wire logic [3:0] elec_half,
   input  wire logic [3:0] ref_half,
   // Oscillator outputs.
   output logic            electrode_osc,
   output logic            reference_osc
);
   int e_cnt; // Cycles into the electrode half period.
   int r_cnt; // Cycles into the reference half period.
   // Both rest low between scans.
   always @(posedge clock) begin
      if (reset || !run) begin
         e_cnt <= 0;
         r_cnt <= 0;
         electrode_osc <= 1'b0;
         reference_osc <= 1'b0;
      end else begin
         e_cnt <= (e_cnt + 1 >= elec_half) ? 0 : e_cnt + 1;
         r_cnt <= (r_cnt + 1 >= ref_half) ? 0 : r_cnt + 1;
         if (e_cnt + 1 >= elec_half) electrode_osc <= !electrode_osc;
         if (r_cnt + 1 >= ref_half) reference_osc <= !reference_osc;
      end
   end
endmodule // tscr_osc_model

// file: tb/tscr_sva.sv
`timescale 1ns/1ps
// Checks at the ports of the readout block.
module tscr_checker import tscr_pkg::*; (
   // Clock, reset and enable.
   input wire logic            clock,
   input wire logic            reset,
   input wire logic            clock_enable,
   // Register bus.
   input wire logic [4:0]      address,
   input wire logic            read,
   input wire logic            write,
   input wire logic [31:0]     writedata,
   input wire logic [31:0]     readdata,
   input wire logic            waitrequest,
   // Sense side and requests.
   input wire logic            electrode_osc,
   input wire logic            hardware_trigger,
   input wire logic            dma_request,
   input wire tscr_analog_type analog_ff,
   input wire logic            scan_active,
   input wire logic            irq
);
   default clocking @(posedge clock); endclocking
   default disable iff (reset);
   logic [31:0] thr_ff;   // Last threshold word written.
   logic [3:0]  since_ff; // Cycles since a start cause, saturating at 15.
   logic [3:0]  edge_ff;  // Electrode rises seen during this scan.
   logic        eprev_ff; // Electrode level one cycle ago.
   wire ack = !waitrequest;
   // Shadow threshold and cycles since a start cause.
   always_ff @(posedge clock) begin
      if (reset) begin
         thr_ff <= 32'h0;
         since_ff <= 4'hf;
      end else begin
         if (write && ack && address == 5'h08) thr_ff <= writedata;
         if (hardware_trigger || (write && address == 5'h04 && writedata[22])) since_ff <= 4'h0;
         else if (since_ff != 4'hf) since_ff <= since_ff + 4'h1;
      end
   end
   // Electrode rises seen inside a scan.
   always_ff @(posedge clock) begin
      eprev_ff <= electrode_osc;
      if (reset || !scan_active) edge_ff <= 4'h0;
      else if (electrode_osc && !eprev_ff && edge_ff != 4'hf) edge_ff <= edge_ff + 4'h1;
   end
   property p_rsv_zero;
      read && ack && address == 5'h04 |-> readdata[27:24] == 4'h0 && readdata[22:16] == 7'h0;
   endproperty
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved result bits set");
   property p_unmapped;
      read && ack && address > 5'h10 |-> readdata == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_thr;
      read && ack && address == 5'h08 |-> readdata == thr_ff;
   endproperty
   a_thr: assert property (p_thr) else $error("threshold readback wrong");
   property p_chan;
      $changed(analog_ff.channel) |-> $past(write && address == 5'h04)
         || $past(write && address == 5'h04, 2) || $past(write && address == 5'h04, 3);
   endproperty
   a_chan: assert property (p_chan) else $error("channel moved without a write");
   property p_start;
      $rose(scan_active) |-> since_ff <= 4'd12;
   endproperty
   a_start: assert property (p_start) else $error("scan began without a trigger");
   property p_irq_dma;
      dma_request |-> !irq;
   endproperty
   a_irq_dma: assert property (p_irq_dma) else $error("irq and dma request together");
   property p_wait_one;
      ack && clock_enable |=> waitrequest;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("answer held too long");
   property p_scan_edges;
      $fell(scan_active) |-> edge_ff >= 4'd1;
   endproperty
   a_scan_edges: assert property (p_scan_edges) else $error("scan ended early");
endmodule // tscr_checker
bind tscr_top tscr_checker u_tscr_checker (.clock(clock),
   .reset(reset), .clock_enable(clock_enable), .address(address), .read(read), .write(write),
   .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
   .electrode_osc(electrode_osc), .hardware_trigger(hardware_trigger),
   .dma_request(dma_request), .analog_ff(analog_ff), .scan_active(scan_active), .irq(irq));

// file: tb/tb.sv
`timescale 1ns/1ps
// Self-checking bench.
module tb import tscr_pkg::*;;
   logic            clock = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, hw_trig = 1'b0;
   logic            dma_done = 1'b0, waitrequest, dma_request, scan_active, irq, e_osc, r_osc;
   logic [4:0]      address = 5'h0;
   logic [31:0]     writedata = 32'h0, readdata, rd;
   logic [3:0]      eh = 4'h2, rh = 4'h2;
   tscr_analog_type analog_ff;
   int              n_fail = 0, cmp_count = 0, ps, ns, ch, ex, c;
   always #10 clock = ~clock;
   tscr_top u_tscr_top (.clock(clock), .reset(reset),
      .clock_enable(1'b1), .address(address), .read(read), .write(write),
      .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
      .electrode_osc(e_osc), .reference_osc(r_osc), .hardware_trigger(hw_trig),
      .dma_done(dma_done), .dma_request(dma_request), .analog_ff(analog_ff),
      .scan_active(scan_active), .irq(irq));
   tscr_osc_model u_tscr_osc_model (.clock(clock), .reset(reset), .run(scan_active),
      .elec_half(eh), .ref_half(rh), .electrode_osc(e_osc), .reference_osc(r_osc));
   // Counts a comparison and reports any difference at once.
   task automatic check(input logic [31:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         n_fail++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One bus cycle, held until waitrequest is sampled low.
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int k = 0;
      address <= a;
      writedata <= d;
      write <= wr;
      read <= !wr;
      @(posedge clock);
      while (waitrequest !== 1'b0 && k < 50) begin
         @(posedge clock);
         k++;
      end
      if (k == 50) n_fail++;
      rd = readdata;
      write <= 1'b0;
      read <= 1'b0;
      @(posedge clock);
   endtask
   // Waits, bounded, for one whole scan.
   task automatic wait_scan();
      int k = 0;
      while (scan_active !== 1'b1 && k < 200) begin
         @(posedge clock);
         k++;
      end
      while (scan_active !== 1'b0 && k < 3000) begin
         @(posedge clock);
         k++;
      end
      check({31'h0, k < 3000}, 32'h1);
      repeat (4) @(posedge clock);
   endtask
   // Control register word.
   function automatic logic [31:0] ctl(int m, int ie, int es, int p, int n, int q);
      return ((q ^ 7) << 28) | (q << 24) | (n << 16) | (p << 8) | (es << 2) | (ie << 1) | m;
   endfunction
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Catches a hang only.
   initial begin
      #(20 * 60000);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      void'($urandom(32'h1e7a));
      repeat (6) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      bus(0, 5'h08, 0);
      check(rd, 32'h0);
      ex = $urandom;
      bus(1, 5'h08, ex);
      bus(0, 5'h08, 0);
      check(rd, ex);
      $display("threshold test done");
      // Every channel, reserved bits written as ones.
      for (ch = 0; ch < 16; ch++) begin
         bus(1, 5'h04, (ch << 28) | 32'h0f3f_ffff);
         bus(0, 5'h04, 0);
         check(rd, ch << 28);
         check(analog_ff.channel, ch);
         check(scan_active, 1'b0);
      end
      for (c = 0; c < 8; c++) begin
         bus(1, 5'h00, ctl(0, 0, 0, 0, 0, c));
         @(posedge clock);
         check(analog_ff.electrode_charge_current, c);
         check(analog_ff.reference_charge_current, c ^ 7);
      end
      bus(1, 5'h14, 32'hffff_ffff);
      bus(0, 5'h14, 0);
      check(rd, 32'h0);
      $display("field test done");
      // Software scans with random settings.
      bus(1, 5'h08, 32'hffff_0000);
      for (int i = 0; i < 6; i++) begin
         ps = $urandom % 3;
         ns = $urandom % 4;
         ch = $urandom % 16;
         eh <= 4'(2 + $urandom % 3);
         rh <= 4'(2 + $urandom % 2);
         bus(1, 5'h10, i % 2);
         bus(1, 5'h00, ctl(0, 1, 1, ps, ns, i));
         bus(1, 5'h04, (ch << 28) | 32'h0040_0000);
         wait_scan();
         check(irq, i % 2);
         ex = ((2 * ((ns + 1) << ps) - 1) * eh + rh) / (2 * rh);
         bus(0, 5'h04, 0);
         check({31'h0, int'(rd[15:0]) >= ex - 2 && int'(rd[15:0]) <= ex + 2}, 1);
         check(rd[31:28], ch);
         bus(0, 5'h00, 0);
         check(rd[3], 1'b1);
         bus(0, 5'h0c, 0);
         check(rd, 32'h1);
         bus(1, 5'h00, ctl(0, 1, 1, ps, ns, i) | 32'h8);
         bus(0, 5'h00, 0);
         check(rd[3], 1'b0);
         check(irq, 1'b0);
      end
      $display("software scan test done");
      bus(1, 5'h00, ctl(1, 1, 1, 0, 0, 0));
      bus(1, 5'h04, 32'h0040_0000);
      repeat (40) @(posedge clock);
      check(scan_active, 1'b0);
      hw_trig <= 1'b1;
      repeat (4) @(posedge clock);
      hw_trig <= 1'b0;
      wait_scan();
      bus(0, 5'h00, 0);
      check(rd[3], 1'b1);
      bus(1, 5'h00, ctl(0, 1, 1, 0, 1, 0) | 32'h8);
      $display("hardware trigger test done");
      bus(1, 5'h10, 1);
      bus(1, 5'h04, 32'h00c0_0000);
      wait_scan();
      check(dma_request, 1'b1);
      check(irq, 1'b0);
      dma_done <= 1'b1;
      @(posedge clock);
      dma_done <= 1'b0;
      repeat (3) @(posedge clock);
      check(dma_request, 1'b0);
      bus(0, 5'h00, 0);
      check(rd[3], 1'b0);
      $display("dma test done");
      tally_and_finish();
   end
endmodule // tb
